//--- hw/spi_port_master_slave.sv
// Behaviour
// - As master the serial clock runs at the system clock over twice the baud divisor, polarity and phase selectable.
// - Every word shifts out and shifts in at once, both timed by the serial clock.
// - As master the port drives its clock pin, sending on the master-out line and capturing the master-in line per pulse.
// - Under DMA as master words keep moving until the word count steps from one to zero, then stop.
// - The DMA engine serves one direction only, chosen by software when the engine is loaded.
// - As slave the port captures on the configured edges only once its slave-select input is asserted.
// - As slave with no transmit word ready the port sends a word of zeros.
// - The device offers one slave-select input and seven slave-select outputs per port, two ports in all.
// - Each port works as master or slave and survives several masters sharing the bus.
// - A DMA transfer raises an interrupt pulse at its end when the loaded block asks for it.
// - A next block queued by software carries on once a DMA transfer completes.
// - Once a transmit block is released the port requests memory words to fill its transmit buffer.
// - The slave-select input takes over its general flag pin when enabled; outputs take over only when enabled on an enabled port in master mode.
// - Each general flag pin has its own software direction when not claimed as a select.
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Transmit FIFO
// ----------------------------------------------------------------------------
// Depth must be a power of two so that the pointers wrap on their own.
module spipm_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr;
    logic [AW-1:0]       rd;
    logic [CW-1:0]       cnt;
    logic                room;
    logic                avail;
  } spipm_fifo_st_t;

  spipm_fifo_st_t s;
  spipm_fifo_st_t next_s;
  logic           push;
  logic           pop;

  always_comb begin
    next_s = s;
    push = inValid && s.room;
    pop = outReady && s.avail;
    if (push) begin
      next_s.mem[s.wr] = inData;
      next_s.wr = s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = s.rd + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
    next_s.room = next_s.cnt != CW'(D);
    next_s.avail = next_s.cnt != '0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.room <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign inReady = s.room;
  assign outValid = s.avail;
  assign outData = s.mem[s.rd];
endmodule

// ----------------------------------------------------------------------------
// Serial port, master and slave, with DMA word counting
// ----------------------------------------------------------------------------
module spipm_port
  import spipm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              portEnable,
  input  wire logic              masterMode,
  input  wire logic              clkPol,
  input  wire logic              clkPhase,
  input  wire logic              wordWide,
  input  wire logic [DIV_W-1:0]  baudDivisor,
  input  wire logic              txValid,
  input  wire logic [DATA_W-1:0] txData,
  output logic                   txReady,
  output logic                   rxValid,
  output logic [DATA_W-1:0]      rxData,
  input  wire logic              rxReady,
  input  wire logic              blockLoad,
  input  wire logic [CNT_W-1:0]  blockWords,
  input  wire logic              blockDirTx,
  input  wire logic              blockIrqReq,
  output logic                   dmaActive,
  output logic [CNT_W-1:0]       dmaRemain,
  output logic                   dmaTxReq,
  output logic                   dmaDone,
  output logic                   dmaIrq,
  input  wire logic              slaveSelectInEnable,
  input  wire logic [FLAG_N-1:1] slaveSelectOutEnable,
  input  wire logic [FLAG_N-1:1] slaveSelectOutAssert,
  input  wire logic [FLAG_N-1:0] flagDir,
  input  wire logic [FLAG_N-1:0] flagOutValue,
  input  wire logic [FLAG_N-1:0] generalFlagIn,
  output logic [FLAG_N-1:0]      generalFlagOut,
  output logic [FLAG_N-1:0]      generalFlagOe_b,
  output logic [FLAG_N-1:0]      flagState,
  input  wire logic              serialClockIn,
  output logic                   serialClockOut,
  output logic                   serialClockOe_b,
  input  wire logic              mosiIn,
  output logic                   mosiOut,
  output logic                   mosiOe_b,
  input  wire logic              misoIn,
  output logic                   misoOut,
  output logic                   misoOe_b,
  output logic                   busy,
  output logic                   modeFault
);
  typedef struct packed {
    spipm_state_t      st;
    logic [DIV_W-1:0]  div;
    logic [DATA_W-1:0] tx;
    logic [DATA_W-1:0] rx;
    logic [DATA_W-1:0] rxData;
    logic [BIT_W-1:0]  bits;
    logic [2:0]        pinS1;
    logic [2:0]        pinS2;
    logic              sclkPrev;
    logic              selPrev;
    logic [FLAG_N-1:0] flagS1;
    logic [FLAG_N-1:0] flagS2;
    logic [FLAG_N-1:0] flagOut;
    logic [FLAG_N-1:0] flagOeB;
    logic              sclk;
    logic              mosi;
    logic              miso;
    logic              sclkOeB;
    logic              mosiOeB;
    logic              misoOeB;
    logic              rxValid;
    logic              busy;
    logic              fault;
    logic              dmaAct;
    logic              dmaDirTx;
    logic              dmaIrqEn;
    logic              dmaDone;
    logic              dmaIrq;
    logic              dmaTxReq;
    logic [CNT_W-1:0]  dmaCnt;
    logic [CNT_W-1:0]  pendCnt;
    logic              pend;
    logic              pendDirTx;
    logic              pendIrq;
  } spipm_st_t;

  spipm_st_t         s;
  spipm_st_t         next_s;
  logic              fifoInReady;
  logic              fifoOutValid;
  logic [DATA_W-1:0] fifoOutData;
  logic              popReq;
  logic [BIT_W-1:0]  len;
  logic [DIV_W-1:0]  half;
  logic              ssIn;
  logic              selected;
  logic              drive;
  logic              lead;
  logic              trail;
  logic              samp;
  logic              done;
  logic              load;
  logic              ob;
  logic              inPin;
  logic              sEdge;
  logic [DATA_W-1:0] word;

  spipm_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) txFifo (
    .clk      (clk),
    .rst_b    (rst_b),
    .inValid  (txValid),
    .inData   (txData),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutData),
    .outReady (popReq)
  );

  always_comb begin
    next_s = s;
    next_s.pinS1 = {serialClockIn, mosiIn, misoIn};
    next_s.pinS2 = s.pinS1;
    next_s.sclkPrev = s.pinS2[2];
    next_s.flagS1 = generalFlagIn;
    next_s.flagS2 = s.flagS1;
    len = wordWide ? LEN_WIDE : LEN_BYTE;
    half = (baudDivisor == '0) ? DIV_MIN : baudDivisor;
    ssIn = slaveSelectInEnable && !s.flagS2[SS_IN_PIN];
    selected = ssIn && portEnable && !masterMode;
    drive = portEnable && masterMode && !s.fault;
    next_s.fault = (portEnable && masterMode && ssIn) || (s.fault && masterMode);
    word = fifoOutValid ? fifoOutData : ZERO_WORD;
    inPin = masterMode ? s.pinS2[0] : s.pinS2[1];
    sEdge = s.pinS2[2] != s.sclkPrev;
    ob = masterMode ? s.mosi : s.miso;
    lead = 1'b0;
    trail = 1'b0;
    load = 1'b0;
    popReq = 1'b0;
    if (rxReady) begin
      next_s.rxValid = 1'b0;
    end
    case (s.st)
      ST_IDLE: begin
        next_s.sclk = clkPol;
        if (drive && (fifoOutValid || (s.dmaAct && !s.dmaDirTx))) begin
          load = 1'b1;
          next_s.st = ST_LEAD;
        end else if (selected && !s.selPrev) begin
          load = 1'b1;
          next_s.st = ST_SLV;
        end
      end
      ST_LEAD, ST_TRAIL: begin
        if (!drive) begin
          next_s.st = ST_IDLE;
        end else if (s.div == half - DIV_MIN) begin
          next_s.div = '0;
          next_s.sclk = !s.sclk;
          lead = s.st == ST_LEAD;
          trail = s.st == ST_TRAIL;
          next_s.st = lead ? ST_TRAIL : ST_LEAD;
        end else begin
          next_s.div = s.div + DIV_MIN;
        end
      end
      ST_SLV: begin
        if (!selected) begin
          next_s.st = ST_IDLE;
        end else begin
          lead = sEdge && (s.pinS2[2] != clkPol);
          trail = sEdge && (s.pinS2[2] == clkPol);
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase

    // Output changes on one edge, input is taken on the other.
    if (lead && clkPhase) begin
      ob = spipm_msb(s.tx, wordWide);
      next_s.tx = s.tx << 1;
    end
    if (trail && !clkPhase && s.bits != '0) begin
      next_s.tx = s.tx << 1;
      ob = spipm_msb(next_s.tx, wordWide);
    end
    samp = clkPhase ? trail : lead;
    if (samp) begin
      next_s.rx = {s.rx[DATA_W-2:0], inPin};
      next_s.bits = s.bits + 1'b1;
    end
    done = (s.st == ST_SLV) ? (samp && next_s.bits == len) : (trail && next_s.bits == len);
    if (done) begin
      next_s.rxData = wordWide ? next_s.rx : (next_s.rx & BYTE_MASK);
      next_s.rxValid = 1'b1;
      next_s.bits = '0;
      if (s.st == ST_SLV) begin
        load = 1'b1;
      end else begin
        next_s.st = ST_IDLE;
      end
    end
    if (load) begin
      next_s.tx = word;
      popReq = fifoOutValid;
      if (!done) begin
        next_s.rx = '0;
        next_s.bits = '0;
      end
      next_s.div = '0;
      ob = clkPhase ? 1'b0 : spipm_msb(word, wordWide);
    end
    if (masterMode) begin
      next_s.mosi = ob;
    end else begin
      next_s.miso = ob;
    end

    // DMA word count and queued block.
    next_s.dmaDone = 1'b0;
    next_s.dmaIrq = 1'b0;
    if (done && s.dmaAct) begin
      if (s.dmaCnt == CNT_LAST) begin
        next_s.dmaAct = 1'b0;
        next_s.dmaCnt = '0;
        next_s.dmaDone = 1'b1;
        next_s.dmaIrq = s.dmaIrqEn;
        if (s.pend) begin
          next_s.dmaAct = 1'b1;
          next_s.dmaCnt = s.pendCnt;
          next_s.dmaDirTx = s.pendDirTx;
          next_s.dmaIrqEn = s.pendIrq;
          next_s.pend = 1'b0;
        end
      end else begin
        next_s.dmaCnt = s.dmaCnt - CNT_LAST;
      end
    end
    if (blockLoad && blockWords != '0) begin
      if (!next_s.dmaAct) begin
        next_s.dmaAct = 1'b1;
        next_s.dmaCnt = blockWords;
        next_s.dmaDirTx = blockDirTx;
        next_s.dmaIrqEn = blockIrqReq;
      end else begin
        next_s.pend = 1'b1;
        next_s.pendCnt = blockWords;
        next_s.pendDirTx = blockDirTx;
        next_s.pendIrq = blockIrqReq;
      end
    end
    next_s.dmaTxReq = next_s.dmaAct && next_s.dmaDirTx && fifoInReady;

    next_s.sclkOeB = !drive;
    next_s.mosiOeB = !drive;
    next_s.misoOeB = !selected;
    next_s.selPrev = selected;
    next_s.busy = next_s.st != ST_IDLE;
    for (int i = 0; i < FLAG_N; i++) begin
      next_s.flagOut[i] = flagOutValue[i];
      next_s.flagOeB[i] = !flagDir[i];
    end
    if (slaveSelectInEnable) begin
      next_s.flagOeB[SS_IN_PIN] = 1'b1;
    end
    for (int i = 1; i < FLAG_N; i++) begin
      if (slaveSelectOutEnable[i] && portEnable && masterMode) begin
        next_s.flagOut[i] = !slaveSelectOutAssert[i];
        next_s.flagOeB[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.sclkOeB <= 1'b1;
      s.mosiOeB <= 1'b1;
      s.misoOeB <= 1'b1;
      s.flagOeB <= '1;
    end else begin
      s <= next_s;
    end
  end

  assign txReady = fifoInReady;
  assign rxValid = s.rxValid;
  assign rxData = s.rxData;
  assign dmaActive = s.dmaAct;
  assign dmaRemain = s.dmaCnt;
  assign dmaTxReq = s.dmaTxReq;
  assign dmaDone = s.dmaDone;
  assign dmaIrq = s.dmaIrq;
  assign generalFlagOut = s.flagOut;
  assign generalFlagOe_b = s.flagOeB;
  assign flagState = s.flagS2;
  assign serialClockOut = s.sclk;
  assign serialClockOe_b = s.sclkOeB;
  assign mosiOut = s.mosi;
  assign mosiOe_b = s.mosiOeB;
  assign misoOut = s.miso;
  assign misoOe_b = s.misoOeB;
  assign busy = s.busy;
  assign modeFault = s.fault;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_IDLE_LEVEL: assert property (
    s.st == ST_IDLE && $past(s.st) == ST_IDLE && !s.sclkOeB |-> s.sclk == $past(clkPol))
    else $error("Idle master clock not at polarity level.");
  AST_BAUD: assert property (
    s.st inside {ST_LEAD, ST_TRAIL} && $past(s.st) != ST_IDLE && $changed(s.sclk)
    |-> $past(s.div) == $past(half) - DIV_MIN)
    else $error("Serial clock toggled off the divider period.");
  AST_MASTER_DRIVE: assert property (
    s.st inside {ST_LEAD, ST_TRAIL} |-> !s.sclkOeB && !s.mosiOeB)
    else $error("Master transfer without driven clock and data.");
  AST_WORD_IN: assert property (
    done |=> s.rxValid && s.bits == '0)
    else $error("Completed word not delivered.");
  AST_DMA_STOP: assert property (
    done && s.dmaAct && s.dmaCnt == CNT_LAST && !s.pend && !blockLoad
    |=> !s.dmaAct && s.dmaDone && s.dmaCnt == '0 ##1 !s.dmaDone)
    else $error("DMA did not stop when count reached zero.");
  AST_SLAVE_SEL: assert property (
    s.st == ST_SLV |-> !s.misoOeB && $past(selected))
    else $error("Slave active without select.");
  AST_ZERO_WORD: assert property (
    s.st == ST_IDLE && !drive && selected && !s.selPrev && !fifoOutValid |=> s.tx == ZERO_WORD)
    else $error("Slave without data did not load zeros.");
  AST_DMA_IRQ: assert property (
    s.dmaIrq |-> s.dmaDone && $past(s.dmaIrqEn))
    else $error("DMA interrupt without requested completion.");
  AST_FAULT: assert property (
    portEnable && masterMode && ssIn |=> s.fault ##1 (s.sclkOeB || !masterMode))
    else $error("Master kept driving after select from another master.");
  AST_SS_OUT: assert property (
    portEnable && masterMode && slaveSelectOutEnable[1]
    |=> !s.flagOeB[1] && s.flagOut[1] == $past(!slaveSelectOutAssert[1]))
    else $error("Select output not driven on its flag pin.");

  COV_MASTER_WORD: cover property (done && s.st == ST_TRAIL);
  COV_SLAVE_WORD: cover property (done && s.st == ST_SLV);
  COV_DMA_CHAIN: cover property (s.dmaDone && s.dmaAct);
endmodule

//--- hw/spipm_pkg.sv
package spipm_pkg;

  localparam int DATA_W     = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int FLAG_N     = 8;
  localparam int SS_IN_PIN  = 0;
  localparam int DIV_W      = 16;
  localparam int CNT_W      = 16;
  localparam int BIT_W      = 5;
  localparam int BYTE_MSB   = 7;

  localparam logic [BIT_W-1:0]  LEN_BYTE  = 5'h08;
  localparam logic [BIT_W-1:0]  LEN_WIDE  = 5'h10;
  localparam logic [DIV_W-1:0]  DIV_MIN   = 16'h0001;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [DATA_W-1:0] BYTE_MASK = 16'h00ff;
  localparam logic [CNT_W-1:0]  CNT_LAST  = 16'h0001;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_TRAIL = 2'b11,
    ST_SLV   = 2'b10
  } spipm_state_t;

  // First bit to go out of a word of either length.
  function automatic logic spipm_msb(input logic [DATA_W-1:0] w, input logic wide);
    spipm_msb = wide ? w[DATA_W-1] : w[BYTE_MSB];
  endfunction

endpackage

//--- bench/spipm_far_slave.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Far-side serial slave with a queue of reply words
// ----------------------------------------------------------------------------
module spipm_far_slave
  import spipm_pkg::*;
(
  input  wire logic         selN,
  input  wire logic         sck,
  input  wire logic         mosi,
  input  wire logic         cpol,
  input  wire logic         cpha,
  input  wire logic         wide,
  output logic              miso,
  output logic [DATA_W-1:0] rxWord
);
  logic [DATA_W-1:0] cur;
  logic [DATA_W-1:0] sh;
  logic [DATA_W-1:0] replyQ[$];
  int                p;
  int                nb;
  int                len;

  // Presents the next bit and takes a fresh reply at each word start.
  task automatic present();
    if (p == len - 1) begin
      cur = (replyQ.size() != 0) ? replyQ.pop_front() : ZERO_WORD;
    end
    miso = cur[p];
    p = (p == 0) ? len - 1 : p - 1;
  endtask

  initial begin
    miso = 1'b1;
    rxWord = ZERO_WORD;
    sh = ZERO_WORD;
    cur = ZERO_WORD;
    len = 16;
    p = 15;
    nb = 0;
  end

  always @(negedge selN) begin
    len = wide ? 16 : 8;
    p = len - 1;
    nb = 0;
    if (!cpha) begin
      present();
    end
  end

  // A released line shows the inverse of its last value.
  always @(posedge selN) begin
    miso = ~miso;
  end

  always @(sck) begin
    if (selN === 1'b0) begin
      if ((sck !== cpol) == cpha) begin
        present();
      end else begin
        sh = {sh[DATA_W-2:0], mosi};
        nb = nb + 1;
        if (nb == len) begin
          rxWord = sh;
          nb = 0;
        end
      end
    end
  end
endmodule

//--- bench/spi_port_master_slave_dma_tb.sv
`timescale 1ns/1ps

module spi_port_master_slave_dma_tb;
  import spipm_pkg::*;

  typedef struct {
    logic [DATA_W-1:0] m;
    logic [DATA_W-1:0] r;
    logic [DATA_W-1:0] f;
  } spipm_note_t;

  logic              clk, rst_b, portEnable, masterMode, clkPol, clkPhase, wordWide;
  logic              txValid, txReady, rxValid, blockLoad, blockDirTx, blockIrqReq;
  logic              dmaActive, dmaTxReq, dmaDone, dmaIrq, slaveSelectInEnable;
  logic              serialClockOut, serialClockOe_b, mosiOut, mosiOe_b, misoOut, misoOe_b;
  logic              busy, modeFault, benchSck, benchMosi, sckPin, mosiPin, misoPin, farMiso;
  logic [DIV_W-1:0]  baudDivisor;
  logic [DATA_W-1:0] txData, rxData, farRx, slvRx, w, r;
  logic [CNT_W-1:0]  blockWords, dmaRemain;
  logic [FLAG_N-1:1] slaveSelectOutEnable, slaveSelectOutAssert;
  logic [FLAG_N-1:0] flagDir, flagOutValue, generalFlagOut, generalFlagOe_b, flagState;
  logic [FLAG_N-1:0] extFlag, pinLvl;
  spipm_note_t       notes[$];
  spipm_note_t       nt;
  int                fail_count, n_tests, hiCnt, doneCnt, irqCnt, cyc;

  assign pinLvl  = (generalFlagOut & ~generalFlagOe_b) | (extFlag & generalFlagOe_b);
  assign sckPin  = serialClockOe_b ? benchSck : serialClockOut;
  assign mosiPin = mosiOe_b ? benchMosi : mosiOut;
  assign misoPin = misoOe_b ? farMiso : misoOut;

  spipm_port spipm_port_i (.clk, .rst_b, .portEnable, .masterMode, .clkPol, .clkPhase,
    .wordWide, .baudDivisor, .txValid, .txData, .txReady, .rxValid, .rxData,
    .rxReady(1'b1), .blockLoad, .blockWords, .blockDirTx, .blockIrqReq, .dmaActive,
    .dmaRemain, .dmaTxReq, .dmaDone, .dmaIrq, .slaveSelectInEnable, .slaveSelectOutEnable,
    .slaveSelectOutAssert, .flagDir, .flagOutValue, .generalFlagIn(pinLvl), .generalFlagOut,
    .generalFlagOe_b, .flagState, .serialClockIn(sckPin), .serialClockOut, .serialClockOe_b,
    .mosiIn(mosiPin), .mosiOut, .mosiOe_b, .misoIn(misoPin), .misoOut, .misoOe_b, .busy,
    .modeFault);

  spipm_far_slave spipm_far_slave_i (.selN(pinLvl[1]), .sck(sckPin), .mosi(mosiPin),
    .cpol(clkPol), .cpha(clkPhase), .wide(wordWide), .miso(farMiso), .rxWord(farRx));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  function automatic logic [DATA_W-1:0] rnd();
    return DATA_W'($urandom);
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string nm, input logic [DATA_W-1:0] e,
                       input logic [DATA_W-1:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Notes one expected word; with far set the reply goes straight onto the far slave's queue.
  task automatic expect_word(input logic [DATA_W-1:0] rw, input logic [DATA_W-1:0] fw,
                             input logic far);
    spipm_note_t n;
    n.m = wordWide ? ~ZERO_WORD : BYTE_MASK;
    n.r = rw & n.m;
    n.f = fw & n.m;
    notes.push_back(n);
    if (far) begin
      spipm_far_slave_i.replyQ.push_back(rw);
    end
  endtask

  // Leaves txValid high; the caller lowers it after the last word.
  task automatic push(input logic [DATA_W-1:0] d);
    txValid = 1'b1;
    txData = d;
    while (txReady !== 1'b1) step(1);
    step(1);
  endtask

  task automatic idle();
    int k;
    k = 0;
    while ((notes.size() != 0 || busy !== 1'b0 || dmaActive !== 1'b0) && k < 5000) begin
      step(1);
      k++;
    end
    if (k == 5000) begin
      fail_count++;
      $display("[ERR] idle expected below 5000 seen %0d", k);
    end
    step(4);
  endtask

  task automatic load(input logic [CNT_W-1:0] n, input logic tx, input logic irq);
    blockWords = n;
    blockDirTx = tx;
    blockIrqReq = irq;
    blockLoad = 1'b1;
    step(1);
    blockLoad = 1'b0;
  endtask

  // Queues every reply before the far slave is selected, then pushes the words.
  task automatic master_words(input int n, input logic sel);
    logic [DATA_W-1:0] ws[$];
    for (int k = 0; k < n; k++) begin
      ws.push_back(rnd());
      expect_word(rnd(), ws[k], 1'b1);
    end
    if (sel) begin
      slaveSelectOutAssert = 7'h01;
      step(3);
    end
    foreach (ws[k]) begin
      push(ws[k]);
    end
    txValid = 1'b0;
  endtask

  // ----------------------------------------------------------------------------
  // Result watcher, pulse counters and hang guard
  // ----------------------------------------------------------------------------
  always @(posedge clk) begin
    if (rxValid === 1'b1) begin
      if (notes.size() == 0) begin
        fail_count++;
        $display("[ERR] rxValid expected 0 seen 1");
      end else begin
        nt = notes.pop_front();
        check("rxData", nt.r, rxData & nt.m);
        check("farWord", nt.f, (masterMode ? farRx : slvRx) & nt.m);
      end
    end
    if (serialClockOe_b === 1'b0 && serialClockOut !== clkPol) hiCnt++;
    if (dmaDone === 1'b1) doneCnt++;
    if (dmaIrq === 1'b1) irqCnt++;
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      $display("[ERR] cycles expected below 30000 seen %0d", cyc);
      finish_test();
    end
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    {rst_b, portEnable, txValid, blockLoad, blockDirTx, blockIrqReq} = '0;
    {clkPol, clkPhase, wordWide, slaveSelectInEnable, benchSck, benchMosi} = '0;
    masterMode = 1'b1;
    baudDivisor = 16'h0003;
    {txData, blockWords, slvRx, w, r} = '0;
    {slaveSelectOutEnable, slaveSelectOutAssert, flagDir, flagOutValue} = '0;
    extFlag = 8'hff;
    {fail_count, n_tests, hiCnt, doneCnt, irqCnt, cyc} = '0;
    void'($urandom(32'hd57d));
    step(5);
    check("released", 16'h01ff, {7'h0, generalFlagOe_b, serialClockOe_b});
    rst_b = 1'b1;
    portEnable = 1'b1;
    w = rnd();
    r = rnd();
    slaveSelectOutEnable = 7'h7f;
    slaveSelectOutAssert = w[7:1];
    step(4);
    check("selOe", 16'h0001, {8'h0, generalFlagOe_b});
    check("selOut", {8'h0, ~w[7:1], 1'b0}, {8'h0, generalFlagOut & 8'hfe});
    slaveSelectOutEnable = 7'h00;
    flagDir = w[15:8];
    flagOutValue = r[7:0];
    extFlag = r[15:8];
    step(5);
    check("flagOe", {8'h0, ~w[15:8]}, {8'h0, generalFlagOe_b});
    check("flagState", {8'h0, (r[7:0] & w[15:8]) | (r[15:8] & ~w[15:8])},
          {8'h0, flagState});
    {extFlag, flagDir} = 16'hff00;
    slaveSelectOutEnable = 7'h01;
    $display("test flags finished");
    for (int c = 0; c < 8; c++) begin
      slaveSelectOutAssert = 7'h00;
      step(2);
      {wordWide, clkPhase, clkPol} = 3'(c);
      benchSck = clkPol;
      baudDivisor = DIV_W'(3 + $urandom_range(2));
      step(1);
      hiCnt = 0;
      master_words(2, 1'b1);
      idle();
      check("sckHigh", DATA_W'(2 * (wordWide ? 16 : 8) * baudDivisor), DATA_W'(hiCnt));
      check("sckIdle", {15'h0, clkPol}, {15'h0, serialClockOut});
    end
    $display("test master modes finished");
    portEnable = 1'b0;
    step(2);
    master_words(FIFO_DEPTH, 1'b0);
    step(2);
    check("txReadyFull", 16'h0, {15'h0, txReady});
    txValid = 1'b1;
    txData = rnd();
    step(3);
    txValid = 1'b0;
    portEnable = 1'b1;
    idle();
    $display("test fifo finished");
    for (int k = 0; k < 4; k++) expect_word(rnd(), ZERO_WORD, 1'b1);
    load(16'h0003, 1'b0, 1'b1);
    step(5);
    load(16'h0001, 1'b0, 1'b0);
    idle();
    check("dmaDone", 16'h0002, DATA_W'(doneCnt));
    check("dmaIrq", 16'h0001, DATA_W'(irqCnt));
    check("dmaRemain", ZERO_WORD, dmaRemain);
    doneCnt = 0;
    load(16'h0002, 1'b1, 1'b0);
    step(2);
    check("dmaTxReq", 16'h0001, {15'h0, dmaTxReq});
    master_words(2, 1'b0);
    idle();
    check("dmaTxDone", 16'h0001, DATA_W'(doneCnt));
    check("dmaTxReqEnd", 16'h0, {15'h0, dmaTxReq});
    $display("test dma finished");
    masterMode = 1'b0;
    slaveSelectOutEnable = 7'h00;
    slaveSelectInEnable = 1'b1;
    {wordWide, clkPhase, clkPol, benchSck} = 4'b1000;
    step(4);
    for (int k = 0; k < 32; k++) begin
      benchSck = ~benchSck;
      step(4);
    end
    w = rnd();
    push(w);
    txValid = 1'b0;
    extFlag[0] = 1'b0;
    step(8);
    for (int k = 0; k < 2; k++) begin
      r = rnd();
      expect_word(r, (k == 0) ? w : ZERO_WORD, 1'b0);
      for (int b = DATA_W - 1; b >= 0; b--) begin
        benchMosi = r[b];
        step(8);
        slvRx = {slvRx[DATA_W-2:0], misoPin};
        benchSck = 1'b1;
        step(8);
        benchSck = 1'b0;
      end
    end
    step(8);
    extFlag[0] = 1'b1;
    idle();
    $display("test slave finished");
    masterMode = 1'b1;
    extFlag[0] = 1'b0;
    step(6);
    check("modeFault", 16'h0001, {15'h0, modeFault});
    check("sckReleased", 16'h0001, {15'h0, serialClockOe_b});
    masterMode = 1'b0;
    step(3);
    check("faultClear", 16'h0, {15'h0, modeFault});
    extFlag[0] = 1'b1;
    step(4);
    $display("test fault finished");
    finish_test();
  end
endmodule
